/* src/eeprom_host_consts.vh */
// Purpose: constants for the byte-wide eeprom host controller
// Assumes: 100 MHz system clock, 10 ns period
// Notes:   times kept in their own unit, cycle counts derived from them
`ifndef EEPROM_HOST_CONSTS_VH
`define EEPROM_HOST_CONSTS_VH

`define CLK_PERIOD_NS          10
`define ADDR_W                 19
`define DIE_ADDR_W             17
`define DIE_COUNT              4
`define POLL_BIT               7
// 15 ms write cycle, waited out in full when no completion sensing is used
`define WRITE_DURATION_MS      15
`define WRITE_DURATION_CYC     (`WRITE_DURATION_MS * 1000000 / `CLK_PERIOD_NS)
// 150 ns least time after the write start point
`define WRITE_START_DELAY_NS   150
`define WRITE_START_DELAY_CYC  ((`WRITE_START_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// 100 us protect pin high before a write
`define PROTECT_SETUP_US       100
`define PROTECT_SETUP_CYC      (`PROTECT_SETUP_US * 1000 / `CLK_PERIOD_NS)
// 100 us byte load timeout, treated as the write start point
`define BYTE_LOAD_TIMEOUT_US   100
`define BYTE_LOAD_TIMEOUT_CYC  (`BYTE_LOAD_TIMEOUT_US * 1000 / `CLK_PERIOD_NS)
// strobe phase lengths: 250 ns pulse, 150 ns address hold, read access and float phases
`define STROBE_NS              250
`define STROBE_CYC             ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_HOLD_NS           150
`define ADDR_HOLD_CYC          ((`ADDR_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_ACCESS_NS         250
`define READ_ACCESS_CYC        ((`READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FLOAT_NS               60
`define FLOAT_CYC              ((`FLOAT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W                  24

`endif

/* src/eeprom_cycle_timer.v */
// Purpose: down counter that times each phase of the host sequence
// Assumes: load and count share the system clock
// Notes:   done is high while the count stands at zero
`timescale 1ns/100ps
`include "eeprom_host_consts.vh"
module eeprom_cycle_timer (
    input  wire              clk_sys_i,
    input  wire              rst_i,
    input  wire              load_i,
    input  wire [`CNT_W-1:0] count_i,
    output wire              done_o
);
    reg [`CNT_W-1:0] cnt_q;

    // reload wins over counting so a phase never ends early
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= {`CNT_W{1'b0}};
        end else if (load_i) begin
            cnt_q <= count_i;
        end else if (cnt_q != {`CNT_W{1'b0}}) begin
            cnt_q <= cnt_q - {{(`CNT_W-1){1'b0}}, 1'b1};
        end
    end

    assign done_o = (cnt_q == {`CNT_W{1'b0}});
endmodule // eeprom_cycle_timer

/* src/eeprom_host_ctrl.v */
// Purpose: host controller driving a four-die byte-wide eeprom over its pins
// Assumes: pin inputs synchronous to clk_sys_i; one request at a time
// Notes:   write completion by polling, by ready line, or by full wait
`timescale 1ns/100ps
`include "eeprom_host_consts.vh"
module eeprom_host_ctrl #(
    parameter WRITE_WAIT_CYC   = `WRITE_DURATION_CYC,
    parameter PROTECT_CYC      = `PROTECT_SETUP_CYC,
    parameter LOAD_TIMEOUT_CYC = `BYTE_LOAD_TIMEOUT_CYC
) (
    input  wire               clk_sys_i,
    input  wire               rst_i,
    input  wire               req_i,
    input  wire               req_write_i,
    input  wire [`ADDR_W-1:0] req_addr_i,
    input  wire [7:0]         req_wdata_i,
    input  wire [1:0]         done_mode_i,
    input  wire               protect_release_i,
    output reg                busy_o,
    output reg                ack_o,
    output reg  [7:0]         rdata_o,
    output reg                timeout_o,
    output reg  [`DIE_COUNT-1:0] die_select_n_o,
    output reg                out_enable_n_o,
    output reg                write_strobe_n_o,
    output reg                protect_release_pin_o,
    output reg  [`DIE_ADDR_W-1:0] byte_address_lines_o,
    output reg  [7:0]         data_o,
    output reg                data_oe_o,
    input  wire [7:0]         data_i,
    input  wire               ready_n_i
);
    localparam S_IDLE    = 4'd0;
    localparam S_PSETUP  = 4'd1;
    localparam S_WSTROBE = 4'd2;
    localparam S_WHOLD   = 4'd3;
    localparam S_WLOAD   = 4'd4;
    localparam S_WSTART  = 4'd5;
    localparam S_POLL    = 4'd6;
    localparam S_POLLEND = 4'd7;
    localparam S_WAITALL = 4'd8;
    localparam S_RACCESS = 4'd9;
    localparam S_RFLOAT  = 4'd10;

    localparam M_POLL  = 2'd0;
    localparam M_READY = 2'd1;
    localparam M_WAIT  = 2'd2;

    reg [3:0]         state_q;
    reg [3:0]         state_d;
    reg [7:0]         last_byte_q;
    reg [`CNT_W-1:0]  prot_cnt_q;
    reg [`CNT_W-1:0]  busy_cnt_q;
    reg [1:0]         mode_q;
    reg [1:0]         sel_q;
    reg               tmr_load;
    reg [`CNT_W-1:0]  tmr_count;
    wire              tmr_done;

    // one-hot active-low select from the two top address bits
    function [`DIE_COUNT-1:0] die_decode;
        input [1:0] sel;
        begin
            die_decode = ~({{(`DIE_COUNT-1){1'b0}}, 1'b1} << sel);
        end
    endfunction

    function [`CNT_W-1:0] to_cnt;
        input integer v;
        begin
            to_cnt = v[`CNT_W-1:0];
        end
    endfunction

    eeprom_cycle_timer u_timer (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .load_i    (tmr_load),
        .count_i   (tmr_count),
        .done_o    (tmr_done)
    );

    // protect pin follows software, high time counted for write setup
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            protect_release_pin_o <= 1'b0;
            prot_cnt_q            <= {`CNT_W{1'b0}};
        end else begin
            // never drop protect mid-cycle, it would abort programming;
            // a request taken this edge keeps the pin high for its access
            if (state_q == S_IDLE && !(req_i && protect_release_pin_o)) begin
                protect_release_pin_o <= protect_release_i;
            end
            if (!protect_release_pin_o) begin
                prot_cnt_q <= {`CNT_W{1'b0}};
            end else if (prot_cnt_q < to_cnt(PROTECT_CYC)) begin
                prot_cnt_q <= prot_cnt_q + {{(`CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // next state and timer load
    always @* begin
        state_d   = state_q;
        tmr_load  = 1'b0;
        tmr_count = {`CNT_W{1'b0}};
        case (state_q)
            S_IDLE: begin
                if (req_i && protect_release_pin_o) begin
                    if (req_write_i) begin
                        state_d = S_PSETUP;
                    end else begin
                        state_d   = S_RACCESS;
                        tmr_load  = 1'b1;
                        tmr_count = to_cnt(`READ_ACCESS_CYC);
                    end
                end
            end
            S_PSETUP: begin
                if (prot_cnt_q >= to_cnt(PROTECT_CYC)) begin
                    state_d   = S_WSTROBE;
                    tmr_load  = 1'b1;
                    tmr_count = to_cnt(`STROBE_CYC);
                end
            end
            S_WSTROBE: begin
                if (tmr_done) begin
                    state_d   = S_WHOLD;
                    tmr_load  = 1'b1;
                    tmr_count = to_cnt(`ADDR_HOLD_CYC);
                end
            end
            S_WHOLD: begin
                if (tmr_done) begin
                    state_d   = S_WLOAD;
                    tmr_load  = 1'b1;
                    tmr_count = to_cnt(LOAD_TIMEOUT_CYC);
                end
            end
            S_WLOAD: begin
                // select and strobe high through the load timeout
                if (tmr_done) begin
                    state_d   = S_WSTART;
                    tmr_load  = 1'b1;
                    tmr_count = to_cnt(`WRITE_START_DELAY_CYC);
                end
            end
            S_WSTART: begin
                if (tmr_done) begin
                    if (mode_q == M_WAIT) begin
                        state_d   = S_WAITALL;
                        tmr_load  = 1'b1;
                        tmr_count = to_cnt(WRITE_WAIT_CYC);
                    end else begin
                        state_d   = S_POLL;
                        tmr_load  = 1'b1;
                        tmr_count = to_cnt(`READ_ACCESS_CYC);
                    end
                end
            end
            S_POLL: begin
                if (tmr_done) begin
                    state_d   = S_POLLEND;
                    tmr_load  = 1'b1;
                    tmr_count = to_cnt(`FLOAT_CYC);
                end
            end
            S_POLLEND: begin
                if (tmr_done) begin
                    state_d   = S_WSTART;
                    tmr_load  = 1'b1;
                    tmr_count = to_cnt(`READ_ACCESS_CYC);
                end
            end
            S_WAITALL: begin
                if (tmr_done) begin
                    state_d = S_IDLE;
                end
            end
            S_RACCESS: begin
                if (tmr_done) begin
                    state_d   = S_RFLOAT;
                    tmr_load  = 1'b1;
                    tmr_count = to_cnt(`FLOAT_CYC);
                end
            end
            S_RFLOAT: begin
                if (tmr_done) begin
                    state_d = S_IDLE;
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    // pin drive and completion handling
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_q              <= S_IDLE;
            die_select_n_o       <= {`DIE_COUNT{1'b1}};
            out_enable_n_o       <= 1'b1;
            write_strobe_n_o     <= 1'b1;
            byte_address_lines_o <= {`DIE_ADDR_W{1'b0}};
            data_o               <= 8'h00;
            data_oe_o            <= 1'b0;
            busy_o               <= 1'b0;
            ack_o                <= 1'b0;
            rdata_o              <= 8'h00;
            timeout_o            <= 1'b0;
            last_byte_q          <= 8'h00;
            mode_q               <= M_POLL;
            sel_q                <= 2'd0;
            busy_cnt_q           <= {`CNT_W{1'b0}};
        end else begin
            state_q <= state_d;
            ack_o   <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    die_select_n_o   <= {`DIE_COUNT{1'b1}};
                    out_enable_n_o   <= 1'b1;
                    write_strobe_n_o <= 1'b1;
                    data_oe_o        <= 1'b0;
                    busy_o           <= 1'b0;
                    if (req_i && protect_release_pin_o) begin
                        busy_o               <= 1'b1;
                        timeout_o            <= 1'b0;
                        mode_q               <= done_mode_i;
                        // die of the request, kept for the strobe and polling reads
                        sel_q                <= req_addr_i[`ADDR_W-1:`DIE_ADDR_W];
                        byte_address_lines_o <= req_addr_i[`DIE_ADDR_W-1:0];
                        data_o               <= req_wdata_i;
                        last_byte_q          <= req_wdata_i;
                        if (!req_write_i) begin
                            die_select_n_o <= die_decode(req_addr_i[`ADDR_W-1:`DIE_ADDR_W]);
                            out_enable_n_o <= 1'b0;
                        end
                    end
                end
                S_PSETUP: begin
                    if (state_d == S_WSTROBE) begin
                        // enable high, select and strobe fall together: address latched
                        die_select_n_o   <= die_decode(sel_q);
                        write_strobe_n_o <= 1'b0;
                        data_oe_o        <= 1'b1;
                    end
                end
                S_WSTROBE: begin
                    if (tmr_done) begin
                        write_strobe_n_o <= 1'b1;
                        die_select_n_o   <= {`DIE_COUNT{1'b1}};
                    end
                end
                S_WHOLD: begin
                    if (tmr_done) begin
                        data_oe_o  <= 1'b0;
                        busy_cnt_q <= {`CNT_W{1'b0}};
                    end
                end
                S_WSTART, S_POLL, S_POLLEND, S_WAITALL: begin
                    if (busy_cnt_q < to_cnt(WRITE_WAIT_CYC)) begin
                        busy_cnt_q <= busy_cnt_q + {{(`CNT_W-1){1'b0}}, 1'b1};
                    end
                    if (state_q == S_WSTART && tmr_done && mode_q != M_WAIT) begin
                        die_select_n_o <= die_decode(sel_q);
                        out_enable_n_o <= 1'b0;
                    end
                    if (state_q == S_POLL && tmr_done) begin
                        die_select_n_o <= {`DIE_COUNT{1'b1}};
                        out_enable_n_o <= 1'b1;
                        // in polling mode bit seven matching the loaded byte ends the cycle, in ready mode a high ready line
                        if ((mode_q == M_POLL &&
                             data_i[`POLL_BIT] == last_byte_q[`POLL_BIT]) ||
                            (mode_q == M_READY && ready_n_i)) begin
                            rdata_o <= data_i;
                            ack_o   <= 1'b1;
                            busy_o  <= 1'b0;
                            state_q <= S_IDLE;
                        end else if (busy_cnt_q >= to_cnt(WRITE_WAIT_CYC)) begin
                            // device should be done by now; give up rather than hang
                            timeout_o <= 1'b1;
                            ack_o     <= 1'b1;
                            busy_o    <= 1'b0;
                            state_q   <= S_IDLE;
                        end
                    end
                    if (state_q == S_WAITALL && tmr_done) begin
                        ack_o  <= 1'b1;
                        busy_o <= 1'b0;
                    end
                end
                S_RACCESS: begin
                    if (tmr_done) begin
                        rdata_o        <= data_i;
                        die_select_n_o <= {`DIE_COUNT{1'b1}};
                        out_enable_n_o <= 1'b1;
                    end
                end
                S_RFLOAT: begin
                    if (tmr_done) begin
                        ack_o  <= 1'b1;
                        busy_o <= 1'b0;
                    end
                end
                default: begin
                    die_select_n_o <= {`DIE_COUNT{1'b1}};
                end
            endcase
        end
    end

endmodule // eeprom_host_ctrl

/* tb/eeprom_host_ctrl_assertions.sv */
// Purpose: pin checks on the eeprom host controller
// Assumes: sees the controller top ports only
// Notes:   age counters saturate so long idle spans cost nothing
`timescale 1ns/100ps
`include "eeprom_host_consts.vh"
module eeprom_host_ctrl_assertions #(
    parameter PROTECT_CYC      = 20,
    parameter LOAD_TIMEOUT_CYC = 20
) (
    input wire                   clk_sys_i,
    input wire                   rst_i,
    input wire [`DIE_COUNT-1:0]  die_select_n_o,
    input wire                   out_enable_n_o,
    input wire                   write_strobe_n_o,
    input wire                   protect_release_pin_o,
    input wire [`DIE_ADDR_W-1:0] byte_address_lines_o,
    input wire [7:0]             data_o,
    input wire                   data_oe_o
);
    localparam int SAT = 1 << 20;
    int prot_age_q;
    int wr_age_q;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    // ages of protect high and of the last strobe rise
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            prot_age_q <= 0;
            wr_age_q   <= SAT;
        end else begin
            prot_age_q <= !protect_release_pin_o ? 0 : prot_age_q + (prot_age_q < SAT);
            wr_age_q   <= !write_strobe_n_o ? 0 : wr_age_q + (wr_age_q < SAT);
        end
    end
    AST_ONE_DIE: assert property ($countones(~die_select_n_o) <= 1)
        else $error("two dies selected together");
    AST_WRITE_DRIVE: assert property (!write_strobe_n_o |-> out_enable_n_o && data_oe_o)
        else $error("strobe low without data drive or with output enable");
    AST_READ_NO_DRIVE: assert property (!out_enable_n_o |-> !data_oe_o && write_strobe_n_o)
        else $error("host drives data during a read");
    AST_PROTECT_SETUP: assert property ($fell(write_strobe_n_o) |-> prot_age_q >= PROTECT_CYC - 1)
        else $error("write began too soon after protect release");
    AST_PROTECT_IDLE: assert property (!protect_release_pin_o |-> &die_select_n_o)
        else $error("die selected while protected");
    AST_STROBE_WIDTH: assert property ($fell(write_strobe_n_o) |->
        (!write_strobe_n_o && !(&die_select_n_o)) [*8]) else $error("strobe pulse too short");
    AST_WRITE_HOLD: assert property (!write_strobe_n_o && $past(!write_strobe_n_o) |->
        $stable(data_o) && $stable(byte_address_lines_o)) else $error("write value moved");
    AST_POLL_GAP: assert property ($fell(out_enable_n_o) |-> wr_age_q >= LOAD_TIMEOUT_CYC + 14)
        else $error("access too soon after write");
endmodule // eeprom_host_ctrl_assertions

bind eeprom_host_ctrl eeprom_host_ctrl_assertions #(
    .PROTECT_CYC(PROTECT_CYC), .LOAD_TIMEOUT_CYC(LOAD_TIMEOUT_CYC)
) u_chk (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .die_select_n_o(die_select_n_o),
    .out_enable_n_o(out_enable_n_o), .write_strobe_n_o(write_strobe_n_o),
    .protect_release_pin_o(protect_release_pin_o), .data_oe_o(data_oe_o),
    .byte_address_lines_o(byte_address_lines_o), .data_o(data_o)
);

/* tb/eeprom_die_model.sv */
// Purpose: behavioural four-die eeprom on the host pins
// Assumes: pins move on the system clock; times in its cycles
// Notes:   released data lines show the inverse of the last byte driven
`timescale 1ns/100ps
module eeprom_die_model #(
    parameter LOAD_CYC = 20,
    parameter PROG_CYC = 60
) (
    input  wire        clk_i,
    input  wire [3:0]  die_select_n_i,
    input  wire        oe_n_i,
    input  wire        we_n_i,
    input  wire        prot_i,
    input  wire [16:0] addr_i,
    input  wire [7:0]  host_data_i,
    output logic [7:0] data_o,
    output wire        ready_n_o
);
    logic [7:0]  mem [0:524287];
    logic [7:0]  last_q = 8'h00, drv_q = 8'h00, rd_val;
    logic        loaded_q = 1'b0, busy_q = 1'b0;
    logic [18:0] addr_q = 19'h00000, cur;
    int          idle_q = 0, prog_q = 0, k;
    // erased cells read all ones
    initial for (k = 0; k < 524288; k = k + 1) mem[k] = 8'hff;
    // each select owns one 128K die
    wire one_die = $onehot(~die_select_n_i);
    wire [1:0] die = !die_select_n_i[3] ? 2'h3 : !die_select_n_i[2] ? 2'h2 :
                     !die_select_n_i[1] ? 2'h1 : 2'h0;
    wire wr_act = one_die & prot_i & oe_n_i & ~we_n_i;
    wire rd_act = one_die & prot_i & ~oe_n_i & we_n_i;
    assign ready_n_o = ~(loaded_q | busy_q);
    // while programming, bit seven reads inverted
    always @* begin
        cur = {die, addr_i};
        rd_val = mem[cur];
        if (busy_q) rd_val = {~last_q[7], drv_q[6:0] ^ 7'h2a};
        data_o = rd_act ? rd_val : ~drv_q;
    end
    // data kept until strobe rises; idle timeout starts programming
    always @(posedge clk_i) begin
        if (rd_act) drv_q <= rd_val;
        if (!prot_i) begin
            loaded_q <= 1'b0;
            busy_q   <= 1'b0;
        end else if (wr_act) begin
            addr_q   <= {die, addr_i};
            last_q   <= host_data_i;
            loaded_q <= 1'b1;
            idle_q   <= 0;
        end else if (loaded_q && &die_select_n_i && we_n_i) begin
            idle_q <= idle_q + 1;
            if (idle_q == LOAD_CYC - 1) begin
                loaded_q <= 1'b0;
                busy_q   <= 1'b1;
                prog_q   <= 0;
            end
        end
        if (busy_q && prot_i) begin
            prog_q <= prog_q + 1;
            if (prog_q == PROG_CYC - 1) begin
                busy_q       <= 1'b0;
                mem[addr_q]  <= last_q;
            end
        end
    end
endmodule // eeprom_die_model

/* tb/tb_eeprom_host_ctrl.sv */
// Purpose: self-checking bench for the eeprom host controller
// Assumes: shortened write wait, protect setup and load timeout
// Notes:   inputs move and outputs are sampled on the falling edge
`timescale 1ns/100ps
`include "eeprom_host_consts.vh"
module tb_eeprom_host_ctrl;
    localparam WW = 200;
    localparam [23:0] WD = 24'hc33ca5;
    reg               clk_sys_i = 1'b0, rst_i = 1'b1, req_i = 1'b0, req_write_i = 1'b0;
    reg               protect_release_i = 1'b1;
    reg [`ADDR_W-1:0] req_addr_i = 19'h00000;
    reg [7:0]         req_wdata_i = 8'h00;
    reg [1:0]         done_mode_i = 2'h0;
    wire              busy_o, ack_o, timeout_o, oe_n, we_n, prot, data_oe, ready_n;
    wire [7:0]        rdata_o, dq_out, dq_in;
    wire [3:0]        sel_n;
    wire [16:0]       addr;
    integer           n_mismatch = 0, num_checks = 0, lat = 0, i, rdy_cnt = 0, rdy_base = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    // cycles with the ready line low, compared across each write
    always @(negedge clk_sys_i) if (ready_n === 1'b0) rdy_cnt = rdy_cnt + 1;
    eeprom_host_ctrl #(.WRITE_WAIT_CYC(WW), .PROTECT_CYC(20), .LOAD_TIMEOUT_CYC(20)) uut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req_i), .req_write_i(req_write_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .done_mode_i(done_mode_i),
        .protect_release_i(protect_release_i), .busy_o(busy_o), .ack_o(ack_o),
        .rdata_o(rdata_o), .timeout_o(timeout_o), .die_select_n_o(sel_n),
        .out_enable_n_o(oe_n), .write_strobe_n_o(we_n), .protect_release_pin_o(prot),
        .byte_address_lines_o(addr), .data_o(dq_out), .data_oe_o(data_oe),
        .data_i(dq_in), .ready_n_i(ready_n));
    eeprom_die_model #(.LOAD_CYC(20), .PROG_CYC(60)) dev (
        .clk_i(clk_sys_i), .die_select_n_i(sel_n), .oe_n_i(oe_n), .we_n_i(we_n),
        .prot_i(prot), .addr_i(addr), .host_data_i(dq_out), .data_o(dq_in),
        .ready_n_o(ready_n));
    task check(input [31:0] seen, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", num_checks, n_mismatch);
            if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    // one request, then a bounded wait for its answer
    task op(input w, input [18:0] a, input [7:0] d, input [1:0] m);
        begin
            req_write_i = w;
            req_addr_i = a;
            req_wdata_i = d;
            done_mode_i = m;
            req_i = 1'b1;
            @(negedge clk_sys_i);
            req_i = 1'b0;
            lat = 1;
            while (ack_o !== 1'b1 && lat < 3000) begin
                @(negedge clk_sys_i);
                lat = lat + 1;
            end
            if (lat >= 3000) begin
                n_mismatch = n_mismatch + 1;
                $display("ERROR %0t: no answer", $time);
                stop_test;
            end
        end
    endtask
    task t_protect;
        begin
            check({sel_n, we_n, oe_n, data_oe, busy_o}, 8'hfc);
            protect_release_i = 1'b0;
            repeat (3) @(negedge clk_sys_i);
            check(prot, 0);
            req_write_i = 1'b0;
            req_i = 1'b1;
            lat = 0;
            repeat (40) begin
                @(negedge clk_sys_i);
                if (busy_o !== 1'b0 || sel_n !== 4'hf) lat = lat + 1;
            end
            req_i = 1'b0;
            check(lat, 0);
            protect_release_i = 1'b1;
            repeat (2) @(negedge clk_sys_i);
            check(prot, 1);
            $display("test protect done");
        end
    endtask
    // one write per completion mode, each read back
    task t_writes;
        begin
            for (i = 0; i < 3; i = i + 1) begin
                rdy_base = rdy_cnt;
                op(1'b1, {i[1:0], 17'h00155}, WD[8*i +: 8], i[1:0]);
                check(timeout_o, 0);
                check(rdy_cnt > rdy_base, 1);
                if (i == 2) check(lat >= WW, 1);
                else check(lat > 80, 1);
                op(1'b0, {i[1:0], 17'h00155}, 8'h00, 2'h0);
                check(rdata_o, WD[8*i +: 8]);
            end
            $display("test writes done");
        end
    endtask
    task t_dies;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                op(1'b0, {i[1:0], 17'h00155}, 8'h00, 2'h0);
                check(rdata_o, (i == 3) ? 8'hff : WD[8*i +: 8]);
            end
            $display("test dies done");
        end
    endtask
    initial begin
        repeat (10) @(negedge clk_sys_i);
        check({prot, ack_o, timeout_o, busy_o, sel_n}, 8'h0f);
        rst_i = 1'b0;
        @(negedge clk_sys_i);
        t_protect;
        t_writes;
        t_dies;
        stop_test;
    end
endmodule // tb_eeprom_host_ctrl
